/* verilog/ierc_pkg.sv */
package ierc_pkg;
  // Register word indices (byte offset: index times four)
  localparam logic [7:0] IDX_ENABLE_HIGH  = 8'hEA;
  localparam logic [7:0] IDX_ENABLE_LOW   = 8'hEB;
  localparam logic [7:0] IDX_REQUEST_HIGH = 8'hEC;
  localparam logic [7:0] IDX_REQUEST_LOW  = 8'hED;
  localparam logic [7:0] IDX_EVENT_FLAGS  = 8'hEE;
  localparam logic [7:0] IDX_CPU_CTRL     = 8'hF0;
  localparam logic [7:0] IDX_CPU_STATUS   = 8'hF1;
  localparam int         ADDR_W           = 12;

  // Bits that carry function in each register
  localparam logic [7:0] HIGH_USED_MASK   = 8'hFC;
  localparam logic [7:0] LOW_USED_MASK    = 8'h45;
  localparam logic [7:0] REG_RESET        = 8'h00;
  localparam int         BIT_SERIAL       = 6;
  localparam int         BIT_WATCHDOG     = 2;
  localparam int         BIT_BASIC_TICK   = 0;

  // Source numbering for the priority encoder, lowest number wins
  localparam int         NUM_SRC          = 9;
  localparam logic [3:0] SRC_NONE         = 4'hF;

  // Acceptance timing
  localparam int         ACCEPT_CYCLES    = 8;
  localparam int         STACK_PUSHES     = 3;
  localparam logic [15:0] VEC_BASIC_TICK  = 16'hFFE0;
  localparam logic [15:0] VEC_WATCHDOG    = 16'hFFE2;
  localparam logic [15:0] VEC_TMR2        = 16'hFFE6;
  localparam logic [15:0] VEC_TMR1        = 16'hFFE8;
  localparam logic [15:0] VEC_TMR0        = 16'hFFEA;
  localparam logic [15:0] VEC_SERIAL      = 16'hFFF0;

  typedef enum logic [1:0] {IERC_IDLE, IERC_ACCEPT, IERC_SERVICE} ierc_state_e;
endpackage

/* verilog/ierc_prio.sv */
module ierc_prio
(
  input  wire logic [8:0] req_vec,
  output logic      [3:0] winner
);
  // Fixed polling: index 0 is the highest priority
  function automatic logic [3:0] first_set(input logic [8:0] v);
    logic [3:0] r;
    r = ierc_pkg::SRC_NONE;
    for (int i = 8; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  assign winner = first_set(req_vec);
endmodule

/* verilog/ierc_vec.sv */
module ierc_vec
(
  input  wire logic [3:0]  src,
  output logic      [15:0] vector
);
  // Timer match and overflow share one vector per timer
  always_comb
  begin
    unique case (src)
      4'h0:       vector = ierc_pkg::VEC_SERIAL;
      4'h1, 4'h2: vector = ierc_pkg::VEC_TMR0;
      4'h3, 4'h4: vector = ierc_pkg::VEC_TMR1;
      4'h5, 4'h6: vector = ierc_pkg::VEC_TMR2;
      4'h7:       vector = ierc_pkg::VEC_WATCHDOG;
      4'h8:       vector = ierc_pkg::VEC_BASIC_TICK;
      default:    vector = 16'h0000;
    endcase
  end
endmodule

/* verilog/ierc_top.sv */
// The implementer's own choice: register access over AXI4-Lite.
module ierc_top
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [5:0]  tmr_event,
  input  wire logic        serial_io_event,
  input  wire logic        watchdog_event,
  input  wire logic        basic_tick_event,
  input  wire logic        nmi_event,
  input  wire logic        instr_done,
  input  wire logic        return_from_irq,
  input  wire logic        set_master_enable_instr,
  input  wire logic        clr_master_enable_instr,
  output logic             irq_to_cpu,
  output logic             accept_busy,
  output logic             stack_push,
  output logic             pc_load,
  output logic      [15:0] pc_vector,
  output logic             master_enable
);
  //////////////////////////////////////////////////////////////////////////
  logic [7:0]  en_high_q, en_low_q, req_high_q, req_low_q, flags_q;
  logic [7:0]  req_high_d, req_low_d, flags_d;
  logic        master_q, nmi_block_q, nmi_pend_q, busy_q;
  logic [3:0]  cnt_q, src_q;
  logic        irq_q, push_q, load_q;
  logic [15:0] vec_q;
  ierc_pkg::ierc_state_e state_q;

  // Bus slave state
  logic        aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0]  wstrb_q;
  logic [1:0]  bresp_q, rresp_q;

  function automatic logic [7:0] word_idx(input logic [11:0] a);
    return a[9:2];
  endfunction

  function automatic logic mapped(input logic [7:0] idx);
    return (idx >= ierc_pkg::IDX_ENABLE_HIGH &&
            idx <= ierc_pkg::IDX_EVENT_FLAGS) ||
           idx == ierc_pkg::IDX_CPU_CTRL || idx == ierc_pkg::IDX_CPU_STATUS;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Write path: address and data may arrive in either order
  wire        wr_fire  = aw_have_q && w_have_q && !bvalid_q;
  wire [7:0]  wr_idx   = word_idx(awaddr_q);
  wire        wr_lane0 = wr_fire && wstrb_q[0];
  wire [7:0]  wr_byte  = wdata_q[7:0];
  wire        wr_en_h  = wr_lane0 && wr_idx == ierc_pkg::IDX_ENABLE_HIGH;
  wire        wr_en_l  = wr_lane0 && wr_idx == ierc_pkg::IDX_ENABLE_LOW;
  wire        wr_rq_h  = wr_lane0 && wr_idx == ierc_pkg::IDX_REQUEST_HIGH;
  wire        wr_rq_l  = wr_lane0 && wr_idx == ierc_pkg::IDX_REQUEST_LOW;
  wire        wr_flag  = wr_lane0 && wr_idx == ierc_pkg::IDX_EVENT_FLAGS;
  wire        wr_ctrl  = wr_lane0 && wr_idx == ierc_pkg::IDX_CPU_CTRL;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_have_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= 2'h0;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= mapped(wr_idx) ? 2'h0 : 2'h2;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  //////////////////////////////////////////////////////////////////////////
  // Read path: one cycle from address to data
  wire [7:0] rd_idx = word_idx(s_axi_araddr);
  logic [7:0] rd_byte;
  always_comb
  begin
    unique case (rd_idx)
      ierc_pkg::IDX_ENABLE_HIGH:  rd_byte = en_high_q;
      ierc_pkg::IDX_ENABLE_LOW:   rd_byte = en_low_q;
      ierc_pkg::IDX_REQUEST_HIGH: rd_byte = req_high_q;
      ierc_pkg::IDX_REQUEST_LOW:  rd_byte = req_low_q;
      ierc_pkg::IDX_EVENT_FLAGS:  rd_byte = flags_q;
      ierc_pkg::IDX_CPU_CTRL:     rd_byte = {7'h00, master_q};
      ierc_pkg::IDX_CPU_STATUS:   rd_byte = {state_q, nmi_block_q, src_q, irq_q};
      default:                    rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h000000, rd_byte};
      rresp_q  <= mapped(rd_idx) ? 2'h0 : 2'h2;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  //////////////////////////////////////////////////////////////////////////
  // Source index: 0 serial, 1..6 timers, 7 watchdog, 8 basic tick
  // Serial outranks every timer in the vector priority order
  wire [8:0] pend_vec = {req_low_q[ierc_pkg::BIT_BASIC_TICK],
                         req_low_q[ierc_pkg::BIT_WATCHDOG],
                         req_high_q[2], req_high_q[3], req_high_q[4],
                         req_high_q[5], req_high_q[6], req_high_q[7],
                         req_low_q[ierc_pkg::BIT_SERIAL]};
  wire [8:0] en_vec   = {en_low_q[ierc_pkg::BIT_BASIC_TICK],
                         en_low_q[ierc_pkg::BIT_WATCHDOG],
                         en_high_q[2], en_high_q[3], en_high_q[4],
                         en_high_q[5], en_high_q[6], en_high_q[7],
                         en_low_q[ierc_pkg::BIT_SERIAL]};
  wire [8:0] live_vec = pend_vec & en_vec;
  wire [3:0] winner;
  wire [15:0] win_vec;

  ierc_prio u_prio (.req_vec(live_vec), .winner(winner));
  ierc_vec  u_vec  (.src(winner), .vector(win_vec));

  // Master enable gates everything maskable
  wire maskable_go = master_q && !nmi_block_q &&
                     (|live_vec);
  wire start       = state_q == ierc_pkg::IERC_IDLE && instr_done &&
                     (maskable_go || nmi_pend_q);
  wire take_mask   = start && !nmi_pend_q;
  wire acc_done    = state_q == ierc_pkg::IERC_ACCEPT &&
                     cnt_q == 4'(ierc_pkg::ACCEPT_CYCLES - 1);

  // One-hot clear for the accepted source, in register layout
  wire [8:0] win_hot  = take_mask ? (9'h001 << winner) : 9'h000;
  wire [7:0] clr_high = {win_hot[1], win_hot[2], win_hot[3],
                         win_hot[4], win_hot[5], win_hot[6], 2'b00};
  wire [7:0] clr_low  = {1'b0, win_hot[0], 3'b000, win_hot[7], 1'b0,
                         win_hot[8]};
  wire [7:0] set_high = {tmr_event, 2'b00};
  wire [7:0] set_low  = {1'b0, serial_io_event, 3'b000, watchdog_event,
                         1'b0, basic_tick_event};

  // Set beats any clear in the same cycle
  always_comb
  begin
    req_high_d = req_high_q & ~clr_high;
    req_low_d  = req_low_q & ~clr_low;
    if (wr_rq_h)
      req_high_d = req_high_d &
                   (wr_byte | ~ierc_pkg::HIGH_USED_MASK);
    if (wr_rq_l)
      req_low_d = req_low_d & (wr_byte | ~ierc_pkg::LOW_USED_MASK);
    req_high_d = (req_high_d | set_high) &
                 ierc_pkg::HIGH_USED_MASK;
    req_low_d  = (req_low_d | set_low) & ierc_pkg::LOW_USED_MASK;
    flags_d    = wr_flag ? (flags_q & wr_byte) : flags_q;
    flags_d    = (flags_d | set_high) & ierc_pkg::HIGH_USED_MASK;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      en_high_q  <= ierc_pkg::REG_RESET;
      en_low_q   <= ierc_pkg::REG_RESET;
      req_high_q <= ierc_pkg::REG_RESET;
      req_low_q  <= ierc_pkg::REG_RESET;
      flags_q    <= ierc_pkg::REG_RESET;
    end
    else
    begin
      if (wr_en_h)
        en_high_q <= wr_byte & ierc_pkg::HIGH_USED_MASK;
      if (wr_en_l)
        en_low_q <= wr_byte & ierc_pkg::LOW_USED_MASK;
      req_high_q <= req_high_d;
      req_low_q  <= req_low_d;
      flags_q    <= flags_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Acceptance sequencer
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q     <= ierc_pkg::IERC_IDLE;
      cnt_q       <= '0;
      src_q       <= ierc_pkg::SRC_NONE;
      master_q    <= 1'b0;
      nmi_block_q <= 1'b0;
      nmi_pend_q  <= 1'b0;
      busy_q      <= 1'b0;
    end
    else
    begin
      if (nmi_event)
        nmi_pend_q <= 1'b1;
      else if (start && nmi_pend_q)
        nmi_pend_q <= 1'b0;
      unique case (state_q)
        ierc_pkg::IERC_IDLE:
          if (start)
          begin
            state_q  <= ierc_pkg::IERC_ACCEPT;
            cnt_q    <= '0;
            master_q <= 1'b0;
            busy_q   <= 1'b1;
            src_q    <= nmi_pend_q ? ierc_pkg::SRC_NONE : winner;
            if (nmi_pend_q)
              nmi_block_q <= 1'b1;
          end
        ierc_pkg::IERC_ACCEPT:
          if (acc_done)
          begin
            state_q <= ierc_pkg::IERC_SERVICE;
            busy_q  <= 1'b0;
          end
          else
            cnt_q <= cnt_q + 4'h1;
        ierc_pkg::IERC_SERVICE:
          if (return_from_irq)
          begin
            state_q     <= ierc_pkg::IERC_IDLE;
            nmi_block_q <= 1'b0;
          end
      endcase
      if (state_q != ierc_pkg::IERC_ACCEPT && !start)
      begin
        // Setting this in the handler does not nest; start waits for IERC_IDLE
        if (set_master_enable_instr || (wr_ctrl && wr_byte[0]))
          master_q <= 1'b1;
        else if (clr_master_enable_instr || (wr_ctrl && !wr_byte[0]))
          master_q <= 1'b0;
      end
    end
  end

  // Pushes in cycles 1..3, vector load in the last cycle
  wire push_now = state_q == ierc_pkg::IERC_ACCEPT && cnt_q >= 4'h1 &&
                  cnt_q <= 4'(ierc_pkg::STACK_PUSHES);
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_q  <= 1'b0;
      push_q <= 1'b0;
      load_q <= 1'b0;
      vec_q  <= '0;
    end
    else
    begin
      irq_q  <= maskable_go || nmi_pend_q;
      push_q <= push_now;
      load_q <= acc_done;
      if (start)
        vec_q <= nmi_pend_q ? 16'hFFFE : win_vec;
    end
  end

  assign irq_to_cpu    = irq_q;
  assign accept_busy   = busy_q;
  assign stack_push    = push_q;
  assign pc_load       = load_q;
  assign pc_vector     = vec_q;
  assign master_enable = master_q;

  //////////////////////////////////////////////////////////////////////////
  sequence s_accept_run;
    state_q == ierc_pkg::IERC_ACCEPT [*8];
  endsequence

  a_accept_eight_cycles: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(accept_busy) |-> s_accept_run ##1 !accept_busy)
    else $error("acceptance not eight cycles");
  a_master_cleared: assert property (@(posedge clk) disable iff (!rst_b)
    start |=> !master_q)
    else $error("master enable not cleared on accept");
  a_no_accept_masked: assert property (@(posedge clk) disable iff (!rst_b)
    (start && !nmi_pend_q) |-> master_q)
    else $error("accepted with master enable off");
  a_winner_cleared: assert property (@(posedge clk) disable iff (!rst_b)
    (take_mask && winner == 4'h1 && !tmr_event[5]) |=> !req_high_q[7])
    else $error("accepted request not cleared");
  a_three_pushes: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(accept_busy) |=> ##1 stack_push [*3] ##1 !stack_push)
    else $error("stack push count wrong");
  a_vector_load: assert property (@(posedge clk) disable iff (!rst_b)
    acc_done |=> pc_load ##1 !pc_load)
    else $error("vector load missing");
  a_event_sets_flag: assert property (@(posedge clk) disable iff (!rst_b)
    tmr_event[0] |=> flags_q[2] && req_high_q[2])
    else $error("timer event lost");
  a_irq_gated: assert property (@(posedge clk) disable iff (!rst_b)
    (!master_q && !nmi_pend_q) |=> !irq_to_cpu)
    else $error("interrupt raised while masked");
  a_unused_zero: assert property (@(posedge clk) disable iff (!rst_b)
    en_high_q[1:0] == 2'b00 && req_low_q[7] == 1'b0)
    else $error("unused bit holds a value");
  a_return_from_irq_ends: assert property (@(posedge clk) disable iff (!rst_b)
    (state_q == ierc_pkg::IERC_SERVICE && return_from_irq) |=>
      state_q == ierc_pkg::IERC_IDLE)
    else $error("return did not end service");
endmodule

/* tb/ierc_cpu_model.sv */
module ierc_cpu_model
#(
  parameter int SVC = 30
)
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       accept_busy,
  input  wire logic       pc_load,
  input  wire logic [3:0] gap,
  output logic            instr_done,
  output logic            return_from_irq
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] cnt_q;
  int         svc_q;

  ////////////////////////////////////////////////////////////////////////////
  // Gap sets how fast the core retires instructions: slow or prompt partner
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q           <= 4'h0;
      svc_q           <= 0;
      instr_done      <= 1'b0;
      return_from_irq <= 1'b0;
    end
    else
    begin
      // Nothing retires while acceptance owns the core
      instr_done      <= !accept_busy && (cnt_q >= gap);
      cnt_q           <= (accept_busy || cnt_q >= gap) ? 4'h0 : cnt_q + 4'h1;
      // Fixed-length service routine, ended by the return instruction
      return_from_irq <= (svc_q == 1);
      svc_q           <= pc_load ? SVC : ((svc_q > 0) ? svc_q - 1 : 0);
    end
  end
endmodule

/* tb/ierc_top_bench.sv */
module ierc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int ORD [9] = '{6, 15, 14, 13, 12, 11, 10, 2, 0};
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [5:0]  tmr_event = 6'h00;
  logic        serial_io_event = 1'b0, watchdog_event = 1'b0;
  logic        basic_tick_event = 1'b0, nmi_event = 1'b0;
  logic        set_master_enable_instr = 1'b0, clr_master_enable_instr = 1'b0;
  logic        instr_done, return_from_irq;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, irq_to_cpu, accept_busy, stack_push, pc_load;
  logic        master_enable;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rdat;
  logic [15:0] pc_vector, last_vec;
  logic [7:0]  v;
  logic [3:0]  gap = 4'h3;
  int          err_total = 0, comparisons = 0;
  int          busy_n = 0, push_n = 0, loads = 0, rets = 0;
  int          irq_rise = 0;
  logic        irq_was = 1'b0;

  ierc_top dut (.clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .tmr_event, .serial_io_event, .watchdog_event, .basic_tick_event,
    .nmi_event, .instr_done, .return_from_irq, .set_master_enable_instr,
    .clr_master_enable_instr, .irq_to_cpu, .accept_busy, .stack_push,
    .pc_load, .pc_vector, .master_enable);

  ierc_cpu_model #(.SVC(30)) cpu (.clk, .rst_b, .accept_busy, .pc_load,
    .gap, .instr_done, .return_from_irq);

  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // Mid-cycle sampling keeps the tallies clear of edge races
  always @(negedge clk)
  begin
    busy_n += int'(accept_busy === 1'b1);
    push_n += int'(stack_push === 1'b1);
    rets += int'(return_from_irq === 1'b1);
    irq_rise += int'(irq_to_cpu === 1'b1 && !irq_was);
    irq_was = (irq_to_cpu === 1'b1);
    if (pc_load === 1'b1)
    begin
      loads++;
      last_vec = pc_vector;
    end
  end

  function automatic logic [15:0] exp_pend(input int k);
    logic [15:0] p;
    p = 16'hFC45;
    for (int i = 0; i <= k; i++)
      p[ORD[i]] = 1'b0;
    return p;
  endfunction

  function automatic logic [15:0] exp_vec(input int k);
    if (k == 0)
      return ierc_pkg::VEC_SERIAL;
    if (k < 3)
      return ierc_pkg::VEC_TMR0;
    if (k < 5)
      return ierc_pkg::VEC_TMR1;
    if (k < 7)
      return ierc_pkg::VEC_TMR2;
    return (k == 7) ? ierc_pkg::VEC_WATCHDOG : ierc_pkg::VEC_BASIC_TICK;
  endfunction

  function automatic logic [7:0] msk(input logic [7:0] idx);
    return idx[0] ? ierc_pkg::LOW_USED_MASK : ierc_pkg::HIGH_USED_MASK;
  endfunction

  task automatic cmp_val(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic cmp_cnt(input string nm, input int e, input int g);
    comparisons++;
    if (g != e)
    begin
      err_total++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Trailing edge keeps a following call from driving the same time step
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic a, w, b;
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b = 1'b0;
    while (!b)
    begin
      @(negedge clk);
      a = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clk);
      if (a)
        s_axi_awvalid <= 1'b0;
      if (w)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] idx);
    logic a, r;
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r = 1'b0;
    while (!r)
    begin
      @(negedge clk);
      a = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk);
      if (a)
        s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask

  // Bits: timer events 11..6, serial, watchdog, tick, nmi, set, clear
  task automatic pulse(input logic [11:0] p);
    {tmr_event, serial_io_event, watchdog_event, basic_tick_event, nmi_event,
     set_master_enable_instr, clr_master_enable_instr} <= p;
    @(posedge clk);
    {tmr_event, serial_io_event, watchdog_event, basic_tick_event, nmi_event,
     set_master_enable_instr, clr_master_enable_instr} <= 12'h000;
    @(posedge clk);
  endtask

  task automatic wait_for(ref int c, input int t);
    int n;
    n = 0;
    while (c < t && n < 1000)
    begin
      @(posedge clk);
      n++;
    end
    cmp_cnt("event count", t, c);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h655B));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 5; i++)
    begin
      rd(8'hEA + i[7:0]);
      cmp_val("reset value", 32'h0, rdat);
    end
    rd(8'h10);
    cmp_val("unmapped resp", 32'h2, {30'h0, resp});
    wr(8'h10, 8'hFF);
    cmp_val("unmapped wresp", 32'h2, {30'h0, resp});
    for (int i = 0; i < 2; i++)
    begin
      v = 8'($urandom);
      wr(8'hEA + i[7:0], v);
      rd(8'hEA + i[7:0]);
      cmp_val("enable", {24'h0, v & msk(8'hEA + i[7:0])},
              rdat & {24'h0, msk(8'hEA + i[7:0])});
    end
    wr(8'hEA, 8'hFF);
    wr(8'hEB, 8'hFF);
    pulse(12'hFF8);
    // Core keeps retiring instructions; master flag still off
    repeat (20) @(posedge clk);
    cmp_val("irq masked", 32'h0, {31'h0, irq_to_cpu});
    cmp_cnt("no accept", 0, loads);
    for (int i = 0; i < 3; i++)
    begin
      rd(8'hEC + i[7:0]);
      cmp_val("flags", {24'h0, msk(8'hEC + i[7:0])},
              rdat & {24'h0, msk(8'hEC + i[7:0])});
    end
    v = 8'($urandom);
    wr(8'hEC, v);
    rd(8'hEC);
    cmp_val("write0 clear", {24'h0, v & 8'hFC}, rdat & 32'hFC);
    wr(8'hEE, 8'h00);
    rd(8'hEE);
    cmp_val("event clear", 32'h0, rdat & 32'hFC);
    pulse(12'hFC0);
    wr(8'hEA, 8'h00);
    wr(8'hEB, 8'h00);
    pulse(12'h002);
    cmp_val("master set", 32'h1, {31'h0, master_enable});
    cmp_val("irq no enable", 32'h0, {31'h0, irq_to_cpu});
    pulse(12'h001);
    cmp_val("master clr", 32'h0, {31'h0, master_enable});
    wr(8'hEA, 8'hFF);
    wr(8'hEB, 8'hFF);
    for (int k = 0; k < 9; k++)
    begin
      gap <= 4'(1 + $urandom % 8);
      pulse(12'h002);
      wait_for(loads, k + 1);
      cmp_val("vector", {16'h0, exp_vec(k)}, {16'h0, last_vec});
      cmp_val("master off", 32'h0, {31'h0, master_enable});
      cmp_cnt("busy cycles", 8 * (k + 1), busy_n);
      cmp_cnt("stack pushes", 3 * (k + 1), push_n);
      rd(8'hEC);
      v = rdat[7:0] & 8'hFC;
      rd(8'hED);
      cmp_val("pending", {16'h0, exp_pend(k)},
              {16'h0, v, rdat[7:0] & 8'h45});
      wait_for(rets, k + 1);
    end
    pulse(12'h001);
    wr(8'hEA, 8'h80);
    pulse(12'h800);
    pulse(12'h004);
    wait_for(loads, 10);
    cmp_val("nmi vector", 32'h0000FFFE, {16'h0, last_vec});
    pulse(12'h002);
    repeat (10) @(posedge clk);
    cmp_cnt("nmi blocks", 10, loads);
    wait_for(loads, 11);
    cmp_val("held request", {16'h0, ierc_pkg::VEC_TMR0},
            {16'h0, last_vec});
    // One raised request line per acceptance, none while masked
    cmp_cnt("irq raises", 11, irq_rise);
    test_done;
  end

  initial
  begin
    repeat (30000) @(posedge clk);
    err_total++;
    test_done;
  end
endmodule
